// ===== rtl/sci_link_pkg.sv
// shared constants and types for the science link receiver
package sci_link_pkg;
    localparam int unsigned LINKS       = 3;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned BIT_CNT_W   = 5;
    localparam int unsigned FIFO_DEPTH  = 8192;
    localparam int unsigned FIFO_AW     = 13;
    localparam int unsigned LINK_FIFO_D = 8;
    localparam int unsigned LINK_FIFO_AW = 3;
    localparam logic [BIT_CNT_W-1:0] BITS_PER_WORD = 5'h10;
    localparam logic [FIFO_AW:0] HALF_LEVEL = 14'h1000;
    localparam int unsigned SYS_CLK_MHZ  = 200;
    localparam int unsigned LINK_CLK_MHZ = 1;
    localparam int unsigned SYNC_STAGES  = 2;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] data;
    } word_beat_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_SHIFT = 2'b01,
        RX_DONE  = 2'b11
    } rx_state_t;
endpackage

// ===== rtl/word_fifo.sv
// parameterised fifo with registered read data and fill level
`timescale 1ns/10ps
module word_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = 3
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    // write side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // read side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    // status
    output logic [AW:0]           level_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;
    logic             stage_free;

    // output register refills when empty or consumed
    assign stage_free = !out_valid_o || out_ready_i;
    assign pop        = ce_i && stage_free && (count_r != '0);
    assign push       = ce_i && in_valid_i && in_ready_o;
    assign in_ready_o = (count_r != DEPTH[AW:0]);
    assign level_o    = count_r;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (ce_i && stage_free) begin
            out_valid_o <= pop;
            if (pop) begin
                out_data_o <= mem[rd_ptr_r];
            end
        end
    end
endmodule // word_fifo

// ===== rtl/link_deser.sv
// per-link deserialiser in the link clock domain, gray crossing out
`timescale 1ns/10ps
module link_deser #(
    parameter int unsigned WORD_W = 16
) (
    // link side
    input  wire logic              link_clk_i,
    input  wire logic              link_rst_n_i,
    input  wire logic              frame_i,
    input  wire logic              data_i,
    // system side
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_n_i,
    input  wire logic              sys_ce_i,
    output logic                   word_valid_o,
    output logic [WORD_W-1:0]      word_o
);
    localparam int unsigned AW = sci_link_pkg::LINK_FIFO_AW;
    localparam int unsigned D  = sci_link_pkg::LINK_FIFO_D;

    logic [WORD_W-1:0] shift_r;
    logic [4:0]        bits_r;
    logic [WORD_W-1:0] buf_r [D];
    logic [AW:0]       wbin_r;
    logic [AW:0]       wgray_r;
    logic [AW:0]       rbin_r;
    logic [AW:0]       wgray_s1_r;
    logic [AW:0]       wgray_s2_r;
    logic [AW:0]       wbin_sys;
    logic [AW:0]       wbin_nxt;
    logic              word_done;
    logic              frame_clr_n;

    // frame low holds shift_r and bits_r in clear, so shifting only happens inside a frame
    assign word_done = frame_i && (bits_r == sci_link_pkg::BITS_PER_WORD
                                   - 5'h01);
    assign wbin_nxt  = wbin_r + {{AW{1'b0}}, 1'b1};
    // the clock stops with the frame, so frame low clears the count
    assign frame_clr_n = link_rst_n_i && frame_i;

    always_ff @(posedge link_clk_i or negedge frame_clr_n) begin
        if (!frame_clr_n) begin
            shift_r <= '0;
            bits_r  <= '0;
        end else if (word_done) begin
            bits_r <= '0;
        end else begin
            shift_r <= {shift_r[WORD_W-2:0], data_i};
            bits_r  <= bits_r + 5'h01;
        end
    end

    // no back-pressure toward the sender: slots drain at 200 MHz
    always_ff @(posedge link_clk_i) begin
        if (word_done) begin
            buf_r[wbin_r[AW-1:0]] <= {shift_r[WORD_W-2:0], data_i};
        end
    end

    always_ff @(posedge link_clk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            wbin_r  <= '0;
            wgray_r <= '0;
        end else begin
            if (word_done) begin
                wbin_r  <= wbin_nxt;
                wgray_r <= (wbin_nxt >> 1) ^ wbin_nxt;
            end
        end
    end

    always_comb begin
        wbin_sys = '0;
        for (int i = AW; i >= 0; i--) begin
            wbin_sys[i] = (i == AW) ? wgray_s2_r[i]
                                    : (wbin_sys[i+1] ^ wgray_s2_r[i]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge sys_rst_n_i) begin
        if (!sys_rst_n_i) begin
            wgray_s1_r   <= '0;
            wgray_s2_r   <= '0;
            rbin_r       <= '0;
            word_valid_o <= 1'b0;
            word_o       <= '0;
        end else if (sys_ce_i) begin
            // frozen with the buffer so a word waits for it
            wgray_s1_r   <= wgray_r;
            wgray_s2_r   <= wgray_s1_r;
            word_valid_o <= (wbin_sys != rbin_r);
            if (wbin_sys != rbin_r) begin
                word_o <= buf_r[rbin_r[AW-1:0]];
                rbin_r <= rbin_r + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // link_deser

// ===== rtl/science_link_receive_fifo.sv
// three fast science link receivers with deep buffers and half-full flags
`timescale 1ns/10ps
module science_link_receive_fifo #(
    parameter int unsigned LINKS = sci_link_pkg::LINKS,
    parameter int unsigned DEPTH = sci_link_pkg::FIFO_DEPTH
) (
    // system clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      clk_en_i,
    // links
    input  wire logic [LINKS-1:0]          link_clk_i,
    input  wire logic [LINKS-1:0]          link_frame_i,
    input  wire logic [LINKS-1:0]          link_data_i,
    // drain side, one stream per link
    input  wire logic [LINKS-1:0]          rd_ready_i,
    output logic [LINKS-1:0]               rd_valid_o,
    output logic [LINKS-1:0][15:0]         rd_data_o,
    // status
    output logic [LINKS-1:0]               half_full_irq_o,
    output logic [LINKS-1:0]               overflow_o
);
    localparam int unsigned AW   = $clog2(DEPTH);
    localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);

    logic [1:0] rst_sync_r;
    logic       rst_n;

    // async assert, synchronous release
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    for (genvar g = 0; g < LINKS; g++) begin : g_link
        logic [1:0]            lrst_r;
        sci_link_pkg::word_beat_t beat;
        logic                  in_ready;
        logic                  out_valid;
        logic [15:0]           out_data;
        logic [AW:0]           level;

        // link-domain reset released on the link clock
        always_ff @(posedge link_clk_i[g] or negedge reset_n_i) begin
            if (!reset_n_i) begin
                lrst_r <= 2'b00;
            end else begin
                lrst_r <= {lrst_r[0], 1'b1};
            end
        end

        link_deser #(
            .WORD_W (sci_link_pkg::WORD_W)
        ) u_deser (
            .link_clk_i   (link_clk_i[g]),
            .link_rst_n_i (lrst_r[1]),
            .frame_i      (link_frame_i[g]),
            .data_i       (link_data_i[g]),
            .sys_clk_i    (sys_clk_i),
            .sys_rst_n_i  (rst_n),
            .sys_ce_i     (clk_en_i),
            .word_valid_o (beat.valid),
            .word_o       (beat.data)
        );

        word_fifo #(
            .WIDTH (sci_link_pkg::WORD_W),
            .DEPTH (DEPTH),
            .AW    (AW)
        ) u_fifo (
            .clk_i       (sys_clk_i),
            .rst_n_i     (rst_n),
            .ce_i        (clk_en_i),
            .in_valid_i  (beat.valid),
            .in_ready_o  (in_ready),
            .in_data_i   (beat.data),
            .out_valid_o (out_valid),
            .out_ready_i (rd_ready_i[g]),
            .out_data_o  (out_data),
            .level_o     (level)
        );

        // drain stream stands in for the system bus
        assign rd_valid_o[g] = out_valid;
        assign rd_data_o[g]  = out_data;

        always_ff @(posedge sys_clk_i or negedge rst_n) begin
            if (!rst_n) begin
                half_full_irq_o[g] <= 1'b0;
                overflow_o[g]      <= 1'b0;
            end else if (clk_en_i) begin
                half_full_irq_o[g] <= (level >= HALF);
                // sticky: a word arrived with the buffer full
                if (beat.valid && !in_ready) begin
                    overflow_o[g] <= 1'b1;
                end
            end
        end
    end
endmodule // science_link_receive_fifo

// ===== tb/sci_link_asserts.sv
// port assertions for the science link receiver
`timescale 1ns/10ps
module sci_link_asserts #(
    parameter int unsigned LINKS = 3,
    parameter int unsigned DEPTH = 8192
) (
    // clock and reset
    input wire logic                   sys_clk_i,
    input wire logic                   reset_n_i,
    input wire logic                   clk_en_i,
    // drain and status
    input wire logic [LINKS-1:0]       rd_ready_i,
    input wire logic [LINKS-1:0]       rd_valid_o,
    input wire logic [LINKS-1:0][15:0] rd_data_o,
    input wire logic [LINKS-1:0]       half_full_irq_o,
    input wire logic [LINKS-1:0]       overflow_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    for (genvar i = 0; i < LINKS; i++) begin : g_link
        valid_hold_a:
            assert property (rd_valid_o[i] && !rd_ready_i[i] |=> rd_valid_o[i])
            else $error("word withdrawn");
        data_hold_a:
            assert property (rd_valid_o[i] && !rd_ready_i[i]
                |=> $stable(rd_data_o[i])) else $error("word changed");
        ovf_sticky_a:
            assert property (overflow_o[i] |=> overflow_o[i])
            else $error("overflow cleared");
        ovf_full_a:
            assert property ($rose(overflow_o[i]) |-> rd_valid_o[i])
            else $error("overflow with empty buffer");
    end
    reset_quiet_a:
        assert property ($rose(reset_n_i)
            |-> (rd_valid_o == '0 && overflow_o == '0)[*2])
        else $error("outputs busy after reset");
    half_valid_a:
        assert property ((half_full_irq_o & ~rd_valid_o) == '0)
        else $error("half flag with empty buffer");
    en_hold_valid_a:
        assert property (!clk_en_i |=> $stable(rd_valid_o))
        else $error("valid moved while disabled");
    en_hold_ovf_a:
        assert property (!clk_en_i |=> $stable(overflow_o))
        else $error("overflow moved while disabled");
endmodule // sci_link_asserts

// ===== tb/link_tx_model.sv
// serial senders at the far end of the three links
`timescale 1ns/10ps
module link_tx_model #(
    parameter int unsigned LINKS = 3
) (
    // forwarded clock, frame and data per link
    output logic [LINKS-1:0] link_clk_o,
    output logic [LINKS-1:0] link_frame_o,
    output logic [LINKS-1:0] link_data_o
);
    initial begin
        link_clk_o = '0;
        link_frame_o = '0;
        link_data_o = '0;
    end
    // n bits msb first, sent unasked; clock idles low outside the frame
    task automatic send(input int l, input logic [15:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            link_frame_o[l] = 1'b1;
            link_data_o[l] = w[15-i];
            #7.5 link_clk_o[l] = 1'b1;
            #7.5 link_clk_o[l] = 1'b0;
        end
        link_frame_o[l] = 1'b0;
        link_data_o[l] = ~link_data_o[l];
        // frame stays low for half a period between words
        #7.5;
    endtask
endmodule // link_tx_model

// ===== tb/tb.sv
// self-checking bench for the science link receiver
`timescale 1ns/10ps
module tb;
    localparam int unsigned DEPTH = 64;
    logic             sys_clk_i = 1'b0;
    logic             reset_n_i = 1'b0;
    logic             clk_en_i = 1'b1;
    logic [2:0]       rd_ready_i = '0;
    logic [2:0]       link_clk, link_frame, link_data;
    logic [2:0]       rd_valid_o, half_full_irq_o, overflow_o;
    logic [2:0][15:0] rd_data_o;
    logic [2:0]       stall = '0;
    logic [2:0]       skip = '0;
    logic [15:0]      seed = 16'h5EA6;
    logic [15:0]      wseed [3];
    logic [15:0]      exp_q [3][$];
    int               err_total = 0;
    int               n_tests = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    science_link_receive_fifo #(.DEPTH(DEPTH)) science_link_receive_fifo_inst (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .link_clk_i(link_clk), .link_frame_i(link_frame),
        .link_data_i(link_data), .rd_ready_i(rd_ready_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .half_full_irq_o(half_full_irq_o), .overflow_o(overflow_o));
    link_tx_model link_tx_model_inst (.link_clk_o(link_clk),
        .link_frame_o(link_frame), .link_data_o(link_data));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic keeps(input int n);
        return n == 16;
    endfunction
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        n_tests++;
        if (a !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
            err_total++;
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tx(input int l, input logic [15:0] w, input int n);
        if (keeps(n) && !skip[l]) exp_q[l].push_back(w);
        link_tx_model_inst.send(l, w, n);
    endtask
    // corner words first, random gaps, truncated words of 0 to 15 bits mixed in
    task automatic burst(input int l, input int cnt);
        logic [15:0] corner [3];
        corner = '{16'h0000, 16'hFFFF, 16'h8001};
        #(3.3 * l);
        for (int i = 0; i < cnt; i++) begin
            wseed[l] = lfsr(wseed[l]);
            if (wseed[l][10:8] == 3'h0) tx(l, ~wseed[l], int'(wseed[l][6:3]));
            tx(l, i < 3 ? corner[i] : wseed[l], 16);
            repeat (wseed[l][1:0]) #15;
        end
    endtask

    always @(posedge sys_clk_i) begin
        #1;
        seed = lfsr(seed);
        rd_ready_i = seed[2:0] & ~stall;
        clk_en_i = seed[15:13] != 3'h0;
    end
    // settled mid-cycle; the next rising edge consumes what is seen here
    always @(negedge sys_clk_i) begin
        for (int l = 0; l < 3; l++)
            if (rd_valid_o[l] !== 1'b0 && rd_ready_i[l] && clk_en_i
                && !skip[l]) begin
                if (exp_q[l].size() == 0)
                    chk(16'h0001, 16'h0000);
                else
                    chk(rd_data_o[l], exp_q[l].pop_front());
            end
    end

    initial begin
        for (int l = 0; l < 3; l++) wseed[l] = seed ^ 16'(l + 1);
        fork
            tx(0, 16'h0, 4);
            tx(1, 16'h0, 4);
            tx(2, 16'h0, 4);
            repeat (16) @(posedge sys_clk_i);
        join
        #1 reset_n_i = 1'b1;
        fork tx(0, 16'h0, 3); tx(1, 16'h0, 3); tx(2, 16'h0, 3); join
        fork burst(0, 40); burst(1, 40); burst(2, 40); join
        repeat (100) @(posedge sys_clk_i);
        for (int l = 0; l < 3; l++) chk(16'(exp_q[l].size()), 16'h0000);
        chk({10'h000, half_full_irq_o, overflow_o}, 16'h0000);
        #3 skip[0] = 1'b1;
        stall[0] = 1'b1;
        burst(0, DEPTH + 24);
        chk({13'h0000, overflow_o}, 16'h0001);
        chk({13'h0000, half_full_irq_o}, 16'h0001);
        stall[0] = 1'b0;
        repeat (200) @(posedge sys_clk_i);
        #1 reset_n_i = 1'b0;
        tx(0, 16'h0, 4);
        @(posedge sys_clk_i);
        #1 reset_n_i = 1'b1;
        skip[0] = 1'b0;
        tx(0, 16'h0, 3);
        chk({13'h0000, overflow_o}, 16'h0000);
        chk({13'h0000, half_full_irq_o}, 16'h0000);
        burst(0, 6);
        repeat (100) @(posedge sys_clk_i);
        chk(16'(exp_q[0].size()), 16'h0000);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        err_total++;
        wrap_up();
    end
endmodule // tb

bind science_link_receive_fifo sci_link_asserts #(
    .LINKS(LINKS), .DEPTH(DEPTH)) sci_link_asserts_inst (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .rd_ready_i(rd_ready_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .half_full_irq_o(half_full_irq_o),
    .overflow_o(overflow_o));
